/* design/ppm_defs.svh */
`ifndef PPM_DEFS_SVH
`define PPM_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PPM_IDX_CSR          8'ha4
`define PPM_IDX_BSE          8'ha6
`define PPM_ADDR_W           12

// ----------------------------------------------------------------
// interrupt block byte addresses
// ----------------------------------------------------------------
`define PPM_ADDR_IRQ_STAT    12'h300
`define PPM_ADDR_IRQ_MASK    12'h304

// ----------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------
`define PPM_CSR_WAKE_STATUS  15
`define PPM_CSR_WAKE_EN      8
`define PPM_CSR_PSTATE_HI    1
`define PPM_CSR_PSTATE_LO    0
`define PPM_CSR_RESET        16'h0000

// ----------------------------------------------------------------
// bridge extensions field positions
// ----------------------------------------------------------------
`define PPM_BSE_BPCC_EN      7
`define PPM_BSE_SECONDARY_BUS_ACTION_SELECT        6
`define PPM_BSE_RESET        8'hc0

// ----------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------
`define PPM_IRQ_W            3
`define PPM_IRQ_WAKE         0
`define PPM_IRQ_PSTATE       1
`define PPM_IRQ_D3_TO_D0     2

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define PPM_RESP_OKAY        2'h0
`define PPM_RESP_SLVERR      2'h2

`endif

/* design/ppm_pkg.sv */
package ppm_pkg;

	// power state encoding as software sees it
	typedef enum logic [1:0]
	{
		PPM_D0    = 2'h0,
		PPM_D1    = 2'h1,
		PPM_D2    = 2'h2,
		PPM_D3HOT = 2'h3
	} ppm_pstate_e;

	// one accepted register write
	typedef struct packed
	{
		logic [11:0] addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} ppm_wr_s;

	// one accepted register read
	typedef struct packed
	{
		logic [11:0] addr;
	} ppm_rd_s;

endpackage

/* design/ppm_axil_slave.sv */
`timescale 1ns/1ns
`include "ppm_defs.svh"

module ppm_axil_slave
	import ppm_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic [11:0] i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [11:0] i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic             o_wr_fire,
	output ppm_wr_s          o_wr,
	input  wire logic        i_wr_err,
	output logic             o_rd_fire,
	output ppm_rd_s          o_rd,
	input  wire logic [31:0] i_rd_data,
	input  wire logic        i_rd_err
);

	logic aw_hold_ff, w_hold_ff, ar_hold_ff;
	logic awready_ff, wready_ff, arready_ff, bvalid_ff, rvalid_ff;
	logic nxt_aw_hold, nxt_w_hold, nxt_ar_hold, nxt_bvalid, nxt_rvalid;
	logic [1:0]  bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	ppm_wr_s     wr_ff;
	ppm_rd_s     rd_ff;

	// a write fires once address and data are both held and no answer waits
	assign o_wr_fire = aw_hold_ff & w_hold_ff & ~bvalid_ff;
	assign o_rd_fire = ar_hold_ff & ~rvalid_ff;
	assign o_wr      = wr_ff;
	assign o_rd      = rd_ff;

	// next holding state of each channel
	always_comb
	begin
		nxt_aw_hold = (aw_hold_ff | (i_awvalid & awready_ff)) & ~o_wr_fire;
		nxt_w_hold  = (w_hold_ff | (i_wvalid & wready_ff)) & ~o_wr_fire;
		nxt_ar_hold = (ar_hold_ff | (i_arvalid & arready_ff)) & ~o_rd_fire;
		nxt_bvalid  = o_wr_fire | (bvalid_ff & ~i_bready);
		nxt_rvalid  = o_rd_fire | (rvalid_ff & ~i_rready);
	end

	// handshake flags; ready drops while a channel holds, so one at a time
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			ar_hold_ff <= 1'b0;
			bvalid_ff  <= 1'b0;
			rvalid_ff  <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			arready_ff <= 1'b0;
		end
		else
		begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff  <= nxt_w_hold;
			ar_hold_ff <= nxt_ar_hold;
			bvalid_ff  <= nxt_bvalid;
			rvalid_ff  <= nxt_rvalid;
			awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
			wready_ff  <= ~nxt_w_hold & ~nxt_bvalid;
			arready_ff <= ~nxt_ar_hold & ~nxt_rvalid;
		end
	end

	// payload capture and answers
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			wr_ff    <= '0;
			rd_ff    <= '0;
			bresp_ff <= `PPM_RESP_OKAY;
			rresp_ff <= `PPM_RESP_OKAY;
			rdata_ff <= 32'h0000_0000;
		end
		else
		begin
			if (i_awvalid && awready_ff)
				wr_ff.addr <= i_awaddr;
			if (i_wvalid && wready_ff)
			begin
				wr_ff.data <= i_wdata;
				wr_ff.strb <= i_wstrb;
			end
			if (i_arvalid && arready_ff)
				rd_ff.addr <= i_araddr;
			if (o_wr_fire)
				bresp_ff <= i_wr_err ? `PPM_RESP_SLVERR : `PPM_RESP_OKAY;
			if (o_rd_fire)
			begin
				rdata_ff <= i_rd_data;
				rresp_ff <= i_rd_err ? `PPM_RESP_SLVERR : `PPM_RESP_OKAY;
			end
		end
	end

	assign o_awready = awready_ff;
	assign o_wready  = wready_ff;
	assign o_arready = arready_ff;
	assign o_bvalid  = bvalid_ff;
	assign o_bresp   = bresp_ff;
	assign o_rvalid  = rvalid_ff;
	assign o_rresp   = rresp_ff;
	assign o_rdata   = rdata_ff;

endmodule

/* design/ppm_csr.sv */
`timescale 1ns/1ns
`include "ppm_defs.svh"

module ppm_csr
	import ppm_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_pci_reset_n,
	input  wire logic        i_wake_event,
	input  wire logic [11:0] i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [11:0] i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic             o_wake_n,
	output logic             o_irq,
	output logic             o_internal_reset,
	output logic [1:0]       o_power_state,
	output logic             o_sec_bus_clk_stop,
	output logic             o_sec_bus_power_off
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// byte address of a register held by index
	function automatic logic [11:0] idx_to_addr(input logic [7:0] idx);
		idx_to_addr = {2'b00, idx, 2'b00};
	endfunction

	// true for any address this block answers
	function automatic logic addr_mapped(input logic [11:0] addr);
		addr_mapped = (addr == idx_to_addr(`PPM_IDX_CSR)) ||
			(addr == idx_to_addr(`PPM_IDX_BSE)) ||
			(addr == `PPM_ADDR_IRQ_STAT) ||
			(addr == `PPM_ADDR_IRQ_MASK);
	endfunction

	// secondary bus action for a given state and extension byte
	function automatic logic [1:0] sec_action(input ppm_pstate_e st, input logic [7:0] bse);
		logic d3_ctl;
		d3_ctl = (st == PPM_D3HOT) && bse[`PPM_BSE_BPCC_EN];
		sec_action = {d3_ctl & ~bse[`PPM_BSE_SECONDARY_BUS_ACTION_SELECT], d3_ctl & bse[`PPM_BSE_SECONDARY_BUS_ACTION_SELECT]};
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------

	ppm_wr_s     wr;
	ppm_rd_s     rd;
	logic        wr_fire;
	logic        rd_fire;
	logic [31:0] rd_data;
	logic        wr_csr;
	logic        wr_stat;
	logic        wr_mask;

	logic        pci_reset_n_meta_ff;
	logic        pci_reset_n_sync_ff;
	logic        wake_meta_ff;
	logic        wake_sync_ff;
	logic        wake_prev_ff;
	logic        wake_rise;

	ppm_pstate_e pstate_ff;
	ppm_pstate_e wr_pstate;
	logic        wake_en_ff;
	logic        wake_status_ff;
	logic [7:0]  bse_ff;
	logic        d3_to_d0;
	logic        pstate_change;

	logic [`PPM_IRQ_W-1:0] irq_stat_ff;
	logic [`PPM_IRQ_W-1:0] irq_mask_ff;
	logic [`PPM_IRQ_W-1:0] irq_event;

	logic        wake_n_ff;
	logic        irq_ff;
	logic        int_rst_ff;
	logic        clk_stop_ff;
	logic        power_off_ff;

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------

	// handshakes live in the slave; this level only decodes and stores
	ppm_axil_slave u_axil
	(
		.i_clk     (i_clk),
		.i_rstn    (i_rstn),
		.i_awaddr  (i_awaddr),
		.i_awvalid (i_awvalid),
		.o_awready (o_awready),
		.i_wdata   (i_wdata),
		.i_wstrb   (i_wstrb),
		.i_wvalid  (i_wvalid),
		.o_wready  (o_wready),
		.o_bresp   (o_bresp),
		.o_bvalid  (o_bvalid),
		.i_bready  (i_bready),
		.i_araddr  (i_araddr),
		.i_arvalid (i_arvalid),
		.o_arready (o_arready),
		.o_rdata   (o_rdata),
		.o_rresp   (o_rresp),
		.o_rvalid  (o_rvalid),
		.i_rready  (i_rready),
		.o_wr_fire (wr_fire),
		.o_wr      (wr),
		.i_wr_err  (~addr_mapped(wr.addr)),
		.o_rd_fire (rd_fire),
		.o_rd      (rd),
		.i_rd_data (rd_data),
		.i_rd_err  (~addr_mapped(rd.addr))
	);

	// write decode; unmapped writes change nothing
	assign wr_csr  = wr_fire && (wr.addr == idx_to_addr(`PPM_IDX_CSR));
	assign wr_stat = wr_fire && (wr.addr == `PPM_ADDR_IRQ_STAT);
	assign wr_mask = wr_fire && (wr.addr == `PPM_ADDR_IRQ_MASK);
	assign wr_pstate = ppm_pstate_e'(wr.data[`PPM_CSR_PSTATE_HI:`PPM_CSR_PSTATE_LO]);

	// read image; unused and reserved bits are tied low
	always_comb
	begin
		rd_data = 32'h0000_0000;
		if (rd.addr == idx_to_addr(`PPM_IDX_CSR))
		begin
			rd_data[`PPM_CSR_WAKE_STATUS] = wake_status_ff;
			rd_data[`PPM_CSR_WAKE_EN] = wake_en_ff;
			rd_data[`PPM_CSR_PSTATE_HI:`PPM_CSR_PSTATE_LO] = pstate_ff;
			// data scale, data select, reserved all zero; no dynamic data
		end
		else if (rd.addr == idx_to_addr(`PPM_IDX_BSE))
			rd_data[7:0] = bse_ff;
		else if (rd.addr == `PPM_ADDR_IRQ_STAT)
			rd_data[`PPM_IRQ_W-1:0] = irq_stat_ff;
		else if (rd.addr == `PPM_ADDR_IRQ_MASK)
			rd_data[`PPM_IRQ_W-1:0] = irq_mask_ff;
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------

	// pci reset and wake source arrive from outside the clock domain
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			pci_reset_n_meta_ff <= 1'b0;
			pci_reset_n_sync_ff <= 1'b0;
			wake_meta_ff <= 1'b0;
			wake_sync_ff <= 1'b0;
			wake_prev_ff <= 1'b0;
		end
		else
		begin
			pci_reset_n_meta_ff <= i_pci_reset_n;
			pci_reset_n_sync_ff <= pci_reset_n_meta_ff;
			wake_meta_ff <= i_wake_event;
			wake_sync_ff <= wake_meta_ff;
			wake_prev_ff <= wake_sync_ff;
		end
	end

	// edge taken from the second stage only
	assign wake_rise = wake_sync_ff & ~wake_prev_ff;

	// ----------------------------------------------------------------
	// power state
	// ----------------------------------------------------------------

	// low byte lane carries the state field
	assign pstate_change = wr_csr && wr.strb[0] && (wr_pstate != pstate_ff);
	assign d3_to_d0 = wr_csr && wr.strb[0] && (pstate_ff == PPM_D3HOT) && (wr_pstate == PPM_D0);

	// pci reset returns to D0; the internal D3hot exit reset does not touch it
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			pstate_ff <= PPM_D0;
		else if (!pci_reset_n_sync_ff)
			pstate_ff <= PPM_D0;
		else if (wr_csr && wr.strb[0])
			pstate_ff <= wr_pstate;
	end

	// ----------------------------------------------------------------
	// wake enable and status
	// ----------------------------------------------------------------

	// enable is sticky across pci reset, cleared by the global reset alone
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			wake_en_ff <= 1'b0;
		else if (wr_csr && wr.strb[1])
			wake_en_ff <= wr.data[`PPM_CSR_WAKE_EN];
	end

	// event set beats a simultaneous write-one clear so no wake is lost
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			wake_status_ff <= 1'b0;
		else if (wake_rise)
			wake_status_ff <= 1'b1;
		else if (wr_csr && wr.strb[1] && wr.data[`PPM_CSR_WAKE_STATUS])
			wake_status_ff <= 1'b0;
	end

	// wake output, active low; lags status by one cycle
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			wake_n_ff <= 1'b1;
		else
			wake_n_ff <= ~(wake_status_ff & wake_en_ff);
	end

	// ----------------------------------------------------------------
	// internal reset on D3hot exit
	// ----------------------------------------------------------------

	// one-cycle pulse for the rest of the function; this block's state,
	// wake context included, is deliberately left standing
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			int_rst_ff <= 1'b0;
		else
			int_rst_ff <= d3_to_d0;
	end

	// ----------------------------------------------------------------
	// bridge extensions and secondary bus
	// ----------------------------------------------------------------

	// fixed policy byte; bus writes never reach it
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			bse_ff <= `PPM_BSE_RESET;
		else
			bse_ff <= bse_ff;
	end

	// action only while control is enabled; selector picks clock or power
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			clk_stop_ff  <= 1'b0;
			power_off_ff <= 1'b0;
		end
		else
		begin
			{power_off_ff, clk_stop_ff} <= sec_action(pstate_ff, bse_ff);
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------

	// events: wake seen, state changed, D3hot exit
	always_comb
	begin
		irq_event = '0;
		irq_event[`PPM_IRQ_WAKE] = wake_rise;
		irq_event[`PPM_IRQ_PSTATE] = pstate_change;
		irq_event[`PPM_IRQ_D3_TO_D0] = d3_to_d0;
	end

	// sticky status, write one to clear, a new event wins over the clear
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			irq_stat_ff <= '0;
		else if (wr_stat && wr.strb[0])
			irq_stat_ff <= (irq_stat_ff & ~wr.data[`PPM_IRQ_W-1:0]) | irq_event;
		else
			irq_stat_ff <= irq_stat_ff | irq_event;
	end

	// mask register, one enables the bit onto the output
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			irq_mask_ff <= '0;
		else if (wr_mask && wr.strb[0])
			irq_mask_ff <= wr.data[`PPM_IRQ_W-1:0];
	end

	// level output from a flop, one cycle behind status
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------

	assign o_wake_n            = wake_n_ff;
	assign o_irq               = irq_ff;
	assign o_internal_reset    = int_rst_ff;
	assign o_power_state       = pstate_ff;
	assign o_sec_bus_clk_stop  = clk_stop_ff;
	assign o_sec_bus_power_off = power_off_ff;

endmodule

/* tb/ppm_csr_monitor.sv */
`timescale 1ns/1ns

module ppm_csr_monitor
	import ppm_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_pci_reset_n,
	input  wire logic        i_bready,
	input  wire logic        i_rready,
	input  wire logic        o_awready,
	input  wire logic        o_bvalid,
	input  wire logic        o_rvalid,
	input  wire logic [1:0]  o_rresp,
	input  wire logic [31:0] o_rdata,
	input  wire logic        o_wake_n,
	input  wire logic        o_irq,
	input  wire logic        o_internal_reset,
	input  wire logic [1:0]  o_power_state,
	input  wire logic        o_sec_bus_clk_stop,
	input  wire logic        o_sec_bus_power_off
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	a_bresp_holds: assert property (o_bvalid && !i_bready |=> o_bvalid)
		else $error("write response dropped early");
	a_rdata_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped or changed early");
	a_aw_refused: assert property (o_bvalid |-> !o_awready)
		else $error("write address taken while response pending");
	a_unmapped_zero: assert property (o_rvalid && o_rresp == 2'h2 |-> o_rdata == 32'h0)
		else $error("refused read returned data");

	// ----------------------------------------------------------------
	// power state and secondary bus
	// ----------------------------------------------------------------
	a_power_never_off: assert property (!o_sec_bus_power_off)
		else $error("secondary bus power removed with clock stop selected");
	a_clk_stop_cause: assert property (o_sec_bus_clk_stop |->
		o_power_state == PPM_D3HOT || $past(o_power_state) == PPM_D3HOT)
		else $error("secondary clock stopped outside D3hot");
	a_pstate_cause: assert property (!$stable(o_power_state) |->
		o_bvalid || !$past(i_pci_reset_n, 2) || !$past(i_pci_reset_n, 3))
		else $error("power state changed without write or bus reset");
	a_ireset_pulse: assert property (o_internal_reset |=> !o_internal_reset)
		else $error("internal reset longer than one cycle");
	a_ireset_cause: assert property (o_internal_reset |->
		o_power_state == PPM_D0 && $past(o_power_state) == PPM_D3HOT)
		else $error("internal reset without D3hot to D0 move");

	// ----------------------------------------------------------------
	// wake and interrupt release need a write first
	// ----------------------------------------------------------------
	a_wake_release: assert property ($rose(o_wake_n) |-> $past(o_bvalid) || $past(o_bvalid, 2))
		else $error("wake released without a clearing write");
	a_irq_release: assert property ($fell(o_irq) |-> $past(o_bvalid) || $past(o_bvalid, 2))
		else $error("interrupt dropped without a write");

	c_ireset: cover property (o_internal_reset);
	c_wake: cover property (!o_wake_n);
	c_irq: cover property (o_irq);
	c_clk_stop: cover property (o_sec_bus_clk_stop);
endmodule

/* tb/ppm_host_model.sv */
`timescale 1ns/1ns

module ppm_host_model
	import ppm_pkg::*;
(
	input  wire logic        i_clk,
	output logic [11:0]      o_awaddr,
	output logic             o_awvalid,
	input  wire logic        i_awready,
	output logic [31:0]      o_wdata,
	output logic [3:0]       o_wstrb,
	output logic             o_wvalid,
	input  wire logic        i_wready,
	input  wire logic [1:0]  i_bresp,
	input  wire logic        i_bvalid,
	output logic             o_bready,
	output logic [11:0]      o_araddr,
	output logic             o_arvalid,
	input  wire logic        i_arready,
	input  wire logic [31:0] i_rdata,
	input  wire logic [1:0]  i_rresp,
	input  wire logic        i_rvalid,
	output logic             o_rready
);
	// idle bus from time zero
	initial
	begin
		{o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
		{o_araddr, o_arvalid, o_rready} = '0;
	end

	// one write; no cycle count assumed, the bench timeout ends a hang
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		@(posedge i_clk);
		o_awaddr  <= a;
		o_wdata   <= d;
		o_wstrb   <= s;
		o_awvalid <= 1'b1;
		o_wvalid  <= 1'b1;
		o_bready  <= 1'b1;
		forever
		begin
			@(posedge i_clk);
			if (o_awvalid && i_awready)
				o_awvalid <= 1'b0;
			if (o_wvalid && i_wready)
				o_wvalid <= 1'b0;
			if (i_bvalid)
				break;
		end
		r = i_bresp;
		o_bready <= 1'b0;
	endtask

	// one read
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_clk);
		o_araddr  <= a;
		o_arvalid <= 1'b1;
		o_rready  <= 1'b1;
		forever
		begin
			@(posedge i_clk);
			if (o_arvalid && i_arready)
				o_arvalid <= 1'b0;
			if (i_rvalid)
				break;
		end
		d = i_rdata;
		r = i_rresp;
		o_rready <= 1'b0;
	endtask
endmodule

/* tb/ppm_csr_tb.sv */
`timescale 1ns/1ns
`include "ppm_defs.svh"

`define CHK(nm, e, g) \
	begin \
		checks_done++; \
		if ((g) !== (e)) \
		begin \
			failures++; \
			$display("[FAIL] %s expected %h seen %h", nm, e, g); \
		end \
	end

module ppm_csr_tb
	import ppm_pkg::*;
	;
	localparam logic [11:0] A_CSR = {2'h0, `PPM_IDX_CSR, 2'h0};
	localparam logic [11:0] A_BSE = {2'h0, `PPM_IDX_BSE, 2'h0};
	localparam logic [11:0] A_ST  = `PPM_ADDR_IRQ_STAT;
	localparam logic [11:0] A_MSK = `PPM_ADDR_IRQ_MASK;
	localparam int          LIMIT = 20000;

	logic        clk, rstn, pci_rst_n, wake;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, pstate;
	logic        wake_n, irq, int_rst, clk_stop, pwr_off;
	int          failures, checks_done, cyc_cnt, ireset_cnt;

	ppm_csr u_ppm_csr (.i_clk(clk), .i_rstn(rstn), .i_pci_reset_n(pci_rst_n), .i_wake_event(wake),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rvalid), .i_rready(rready), .o_wake_n(wake_n), .o_irq(irq), .o_internal_reset(int_rst),
		.o_power_state(pstate), .o_sec_bus_clk_stop(clk_stop), .o_sec_bus_power_off(pwr_off));

	ppm_host_model u_host (.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid), .i_awready(awready),
		.o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready), .i_bresp(bresp),
		.i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid),
		.i_arready(arready), .i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));

	// ----------------------------------------------------------------
	// clock and hang guard
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// internal reset pulses are counted so that a single-cycle pulse is never missed
	always @(posedge clk)
	begin
		if (int_rst === 1'b1)
			ireset_cnt++;
		cyc_cnt++;
		if (cyc_cnt == LIMIT)
		begin
			failures++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic w(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'h3,
		input logic [1:0] er = `PPM_RESP_OKAY);
		logic [1:0] rs;
		u_host.wr(a, d, s, rs);
		`CHK("bresp", er, rs)
	endtask

	task automatic r(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er = `PPM_RESP_OKAY);
		logic [31:0] d;
		logic [1:0]  rs;
		u_host.rd(a, d, rs);
		`CHK("rdata", ed, d)
		`CHK("rresp", er, rs)
	endtask

	// rising wake source; status lands three edges later
	task automatic wake_pulse();
		wake <= 1'b0;
		cyc(4);
		wake <= 1'b1;
		cyc(6);
		// back to idle so a later global reset does not meet a high wake pin
		wake <= 1'b0;
	endtask

	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rstn = 1'b0;
		pci_rst_n = 1'b1;
		wake = 1'b0;
		cyc(2);
		rstn <= 1'b1;
		r(A_CSR, 32'h0);
		r(A_BSE, 32'hc0);
		w(A_BSE, 32'h0, 4'h1);
		r(A_BSE, 32'hc0);
		r(12'h100, 32'h0, `PPM_RESP_SLVERR);
		w(12'h100, 32'h1, 4'hf, `PPM_RESP_SLVERR);
		// every state code, read-only bits written as ones
		for (int st = 0; st < 4; st++)
		begin
			w(A_CSR, 32'hffff_fefc | 32'(st), 4'hf);
			r(A_CSR, 32'(st));
			`CHK("power state", 2'(st), pstate)
		end
		`CHK("clock stop", 1'b1, clk_stop)
		`CHK("power off", 1'b0, pwr_off)
		w(A_CSR, 32'h0103);
		w(A_CSR, 32'h0100);
		r(A_CSR, 32'h0100);
		`CHK("internal reset", 1, ireset_cnt)
		`CHK("clock run", 1'b0, clk_stop)
		// wake with enable off, then on
		w(A_CSR, 32'h0);
		wake_pulse();
		`CHK("wake gated", 1'b1, wake_n)
		r(A_CSR, 32'h8000);
		w(A_CSR, 32'h0);
		r(A_CSR, 32'h8000);
		w(A_CSR, 32'h0100);
		cyc(2);
		`CHK("wake driven", 1'b0, wake_n)
		w(A_CSR, 32'h8100);
		cyc(2);
		`CHK("wake cleared", 1'b1, wake_n)
		r(A_CSR, 32'h0100);
		// bus reset spares enable, global reset clears it
		w(A_CSR, 32'h0102);
		pci_rst_n <= 1'b0;
		cyc(5);
		pci_rst_n <= 1'b1;
		cyc(3);
		r(A_CSR, 32'h0100);
		rstn <= 1'b0;
		cyc(2);
		rstn <= 1'b1;
		r(A_CSR, 32'h0);
		// interrupt: raise, mask, clear
		w(A_MSK, 32'h7, 4'h1);
		w(A_ST, 32'h7, 4'h1);
		cyc(2);
		`CHK("irq idle", 1'b0, irq)
		wake_pulse();
		r(A_ST, 32'h1);
		`CHK("irq raised", 1'b1, irq)
		`CHK("wake off", 1'b1, wake_n)
		w(A_ST, 32'h1, 4'h1);
		cyc(2);
		`CHK("irq cleared", 1'b0, irq)
		w(A_MSK, 32'h0, 4'h1);
		wake_pulse();
		`CHK("irq masked", 1'b0, irq)
		w(A_MSK, 32'h1, 4'h1);
		cyc(2);
		`CHK("irq unmasked", 1'b1, irq)
		w(A_ST, 32'h1, 4'h1);
		cyc(2);
		`CHK("irq final", 1'b0, irq)
		`CHK("internal reset once", 1, ireset_cnt)
		results();
	end
endmodule

bind ppm_csr ppm_csr_monitor u_mon (.i_clk(i_clk), .i_rstn(i_rstn), .i_pci_reset_n(i_pci_reset_n),
	.i_bready(i_bready), .i_rready(i_rready), .o_awready(o_awready), .o_bvalid(o_bvalid),
	.o_rvalid(o_rvalid), .o_rresp(o_rresp), .o_rdata(o_rdata), .o_wake_n(o_wake_n), .o_irq(o_irq),
	.o_internal_reset(o_internal_reset), .o_power_state(o_power_state),
	.o_sec_bus_clk_stop(o_sec_bus_clk_stop), .o_sec_bus_power_off(o_sec_bus_power_off));
